/* File: design/ladder_dac_pkg.sv */
package ladder_dac_pkg;
    // Register word offsets (byte addresses, one aligned word each)
    localparam logic [3:0] control_offset = 4'h0;
    localparam logic [3:0] level_offset = 4'h4;
    localparam logic [3:0] pin_status_offset = 4'h8;
    // Field positions in the control register
    localparam int enable_bit = 7;
    localparam int pin1_oe_bit = 5;
    localparam int pin2_oe_bit = 4;
    localparam int pss_hi_bit = 3;
    localparam int pss_lo_bit = 2;
    localparam int nss_bit = 0;
    // Writable masks
    localparam logic [7:0] control_write_mask = 8'hbc;
    localparam logic [7:0] level_write_mask = 8'h1f;
    // Reset values
    localparam logic [7:0] control_reset = 8'h00;
    localparam logic [7:0] level_reset = 8'h00;
    // Level code width and level count
    localparam int level_width = 5;
    localparam int level_count = 32;
    // Positive source encodings
    typedef enum logic [1:0] {
        src_supply = 2'b00,
        src_ext_pin = 2'b01,
        src_fixed = 2'b10,
        src_reserved = 2'b11
    } source_sel_t;
endpackage

/* File: design/pin_override_if.sv */
// Control from the register core to one reference pad override
interface pin_override_if;
    logic route_enable; // Reference routed to this pad
    logic pad_in; // Raw digital pad input level
    logic read_value; // Value software sees for the pad
    logic drv_override; // Digital output driver disabled
    logic thr_override; // Input threshold detector disabled
    logic pullup_disable; // Weak pull-up off
    logic ccd_disable; // Current-controlled drive off
    modport core (output route_enable, output pad_in, input read_value, input drv_override,
        input thr_override, input pullup_disable, input ccd_disable);
    modport pad (input route_enable, input pad_in, output read_value, output drv_override,
        output thr_override, output pullup_disable, output ccd_disable);
endinterface

/* File: design/pin_override.sv */
// One pad overridden while it carries the analog reference
module pin_override (
    input wire logic clk,
    input wire logic sys_rst,
    pin_override_if.pad po
);
    // Registered so top outputs come straight from flops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            po.drv_override <= 1'b0;
            po.thr_override <= 1'b0;
            po.pullup_disable <= 1'b0;
            po.ccd_disable <= 1'b0;
            po.read_value <= 1'b0;
        end else begin
            po.drv_override <= po.route_enable; // see [RQ6]
            po.thr_override <= po.route_enable; // see [RQ6]
            po.pullup_disable <= po.route_enable; // see [RQ6]
            po.ccd_disable <= po.route_enable; // see [RQ6]
            // Analog pad reads zero whatever its voltage
            po.read_value <= po.route_enable ? 1'b0 : po.pad_in; // see [RQ7]
        end
    end

    // Overrides follow the route enable one edge later
    property p_override_follows;
        @(posedge clk) disable iff (sys_rst) po.route_enable |=> po.drv_override && po.pullup_disable;
    endproperty
    a_override_follows: assert property (p_override_follows) else $error("pad override missing"); // see [RQ6]

    property p_read_zero;
        @(posedge clk) disable iff (sys_rst) po.route_enable |=> !po.read_value;
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("routed pad read not zero"); // see [RQ7]
endmodule // pin_override

/* File: design/ladder_dac_control_regs.sv */
// Behaviour
// [RQ1] Converter powered only while enable bit set
// [RQ2] Five-bit level code gives 32 levels
// [RQ3] Level code drives ladder tap directly
// [RQ4] Bits 5,4 route reference to pins
// [RQ5] Source select: supply, pin, fixed, reserved
// [RQ6] Routed pin: digital functions overridden
// [RQ7] Routed pin reads as zero
// [RQ8] Reset clears enable, routes, level code
// [RQ9] Sleep and wake leave control unchanged
// [RQ10] Negative source bit always reads zero
// [RQ11] Bits 6 and 1 read zero
// [RQ12] Writes update controls next edge
module ladder_dac_control_regs
    import ladder_dac_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic sleep_i,
    input wire logic pin1_pad_in,
    input wire logic pin2_pad_in,
    output logic converter_power,
    output logic [4:0] ladder_tap,
    output logic source_supply_sw,
    output logic source_ext_pin_sw,
    output logic source_fixed_sw,
    output logic negative_ground_sw,
    output logic reference_out_pin1,
    output logic reference_out_pin2,
    output logic pin1_read_value,
    output logic pin2_read_value,
    output logic pin1_drv_override,
    output logic pin1_thr_override,
    output logic pin1_pullup_disable,
    output logic pin1_ccd_disable,
    output logic pin2_drv_override,
    output logic pin2_thr_override,
    output logic pin2_pullup_disable,
    output logic pin2_ccd_disable
);
    // Stored fields
    logic converter_enable; // Enable bit
    logic pin1_output_enable; // Route to pin 1
    logic pin2_output_enable; // Route to pin 2
    logic [1:0] positive_source_select; // Positive ladder end
    logic [level_width-1:0] level_code; // Ladder tap code
    // Bus decode
    logic access; // Live request this cycle
    logic write_strobe; // Write committed this cycle
    logic [3:0] word_addr; // Low address bits
    logic [7:0] control_view; // Control register as read
    logic [7:0] level_view; // Level register as read
    logic [7:0] pin_view; // Pad read status
    logic [7:0] wdata; // Low byte of write data

    pin_override_if pad1 ();
    pin_override_if pad2 ();

    assign word_addr = wb_adr_i[3:0];
    // Answer only on a fresh request, so ack falls after one cycle
    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign write_strobe = access && wb_we_i && wb_sel_i[0];
    assign wdata = wb_dat_i[7:0];

    // Read views: unimplemented and negative-source bits forced zero
    always_comb begin
        control_view = 8'h00;
        control_view[enable_bit] = converter_enable;
        control_view[pin1_oe_bit] = pin1_output_enable;
        control_view[pin2_oe_bit] = pin2_output_enable;
        control_view[pss_hi_bit:pss_lo_bit] = positive_source_select;
        control_view[nss_bit] = 1'b0; // see [RQ10] see [RQ11]
        level_view = {3'b000, level_code};
        pin_view = {6'h00, pin2_read_value, pin1_read_value};
    end

    // Ack one cycle after the request, single-cycle pulse
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= access;
        end
    end

    // Read data mux; unmapped offsets read zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (access && !wb_we_i) begin
            case (word_addr)
                control_offset: wb_dat_o <= {24'h000000, control_view};
                level_offset: wb_dat_o <= {24'h000000, level_view};
                pin_status_offset: wb_dat_o <= {24'h000000, pin_view};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Control register; sleep does not touch it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            converter_enable <= control_reset[enable_bit]; // see [RQ8]
            pin1_output_enable <= control_reset[pin1_oe_bit]; // see [RQ8]
            pin2_output_enable <= control_reset[pin2_oe_bit]; // see [RQ8]
            positive_source_select <= control_reset[pss_hi_bit:pss_lo_bit];
        end else if (write_strobe && word_addr == control_offset) begin
            // Masked bits 6,1,0 are simply not stored
            converter_enable <= wdata[enable_bit] & control_write_mask[enable_bit]; // see [RQ12]
            pin1_output_enable <= wdata[pin1_oe_bit]; // see [RQ4]
            pin2_output_enable <= wdata[pin2_oe_bit]; // see [RQ4]
            positive_source_select <= wdata[pss_hi_bit:pss_lo_bit]; // see [RQ5]
        end
    end

    // Level register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            level_code <= level_reset[level_width-1:0]; // see [RQ8]
        end else if (write_strobe && word_addr == level_offset) begin
            level_code <= wdata[level_width-1:0] & level_write_mask[level_width-1:0]; // see [RQ2]
        end
    end

    // Analog controls; no sleep term, converter keeps running asleep
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            converter_power <= 1'b0;
            ladder_tap <= 5'h00;
            source_supply_sw <= 1'b0;
            source_ext_pin_sw <= 1'b0;
            source_fixed_sw <= 1'b0;
            negative_ground_sw <= 1'b0;
            reference_out_pin1 <= 1'b0;
            reference_out_pin2 <= 1'b0;
        end else begin
            converter_power <= converter_enable; // see [RQ1] see [RQ9]
            ladder_tap <= level_code; // see [RQ3]
            // Reserved code closes no switch, so no sources short together
            source_supply_sw <= converter_enable && positive_source_select == src_supply; // see [RQ5]
            source_ext_pin_sw <= converter_enable && positive_source_select == src_ext_pin; // see [RQ5]
            source_fixed_sw <= converter_enable && positive_source_select == src_fixed; // see [RQ5]
            negative_ground_sw <= converter_enable; // see [RQ10]
            reference_out_pin1 <= pin1_output_enable; // see [RQ4]
            reference_out_pin2 <= pin2_output_enable; // see [RQ4]
        end
    end

    // Pad override wiring
    assign pad1.route_enable = pin1_output_enable;
    assign pad1.pad_in = pin1_pad_in;
    assign pad2.route_enable = pin2_output_enable;
    assign pad2.pad_in = pin2_pad_in;
    assign pin1_read_value = pad1.read_value;
    assign pin1_drv_override = pad1.drv_override;
    assign pin1_thr_override = pad1.thr_override;
    assign pin1_pullup_disable = pad1.pullup_disable;
    assign pin1_ccd_disable = pad1.ccd_disable;
    assign pin2_read_value = pad2.read_value;
    assign pin2_drv_override = pad2.drv_override;
    assign pin2_thr_override = pad2.thr_override;
    assign pin2_pullup_disable = pad2.pullup_disable;
    assign pin2_ccd_disable = pad2.ccd_disable;

    pin_override u_pad1 (.clk(clk), .sys_rst(sys_rst), .po(pad1.pad)); // see [RQ6]
    pin_override u_pad2 (.clk(clk), .sys_rst(sys_rst), .po(pad2.pad)); // see [RQ6]

    // Write sequence and its effect
    sequence s_ctrl_write;
        write_strobe && word_addr == control_offset;
    endsequence

    property p_enable_power;
        @(posedge clk) disable iff (sys_rst) s_ctrl_write ##0 wdata[enable_bit] |=> ##1 converter_power;
    endproperty
    a_enable_power: assert property (p_enable_power) else $error("power not on after enable"); // see [RQ1]

    property p_power_tracks;
        @(posedge clk) disable iff (sys_rst) converter_power == $past(converter_enable);
    endproperty
    a_power_tracks: assert property (p_power_tracks) else $error("power differs from enable"); // see [RQ1]

    property p_tap;
        @(posedge clk) disable iff (sys_rst) (write_strobe && word_addr == level_offset)
            |=> ##1 ladder_tap == $past(wb_dat_i[4:0], 2);
    endproperty
    a_tap: assert property (p_tap) else $error("ladder tap mismatch"); // see [RQ3]

    property p_pin1_route;
        @(posedge clk) disable iff (sys_rst) s_ctrl_write |=> ##1 reference_out_pin1 == $past(wdata[pin1_oe_bit], 2);
    endproperty
    a_pin1_route: assert property (p_pin1_route) else $error("pin1 route mismatch"); // see [RQ4]

    property p_one_source;
        @(posedge clk) disable iff (sys_rst) $onehot0({source_supply_sw, source_ext_pin_sw, source_fixed_sw});
    endproperty
    a_one_source: assert property (p_one_source) else $error("two sources closed"); // see [RQ5]

    property p_reserved_bits;
        @(posedge clk) disable iff (sys_rst) control_view[6] == 1'b0 && control_view[1] == 1'b0 && control_view[0] == 1'b0;
    endproperty
    a_reserved_bits: assert property (p_reserved_bits) else $error("reserved bit set"); // see [RQ11]

    property p_reset_clear;
        @(posedge clk) sys_rst |=> !converter_enable && !pin1_output_enable && !pin2_output_enable && level_code == 5'h00;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear"); // see [RQ8]

    property p_sleep_hold;
        @(posedge clk) disable iff (sys_rst) (sleep_i && !write_strobe) |=> $stable(converter_enable);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("control changed in sleep"); // see [RQ9]

    property p_ack_pulse;
        @(posedge clk) disable iff (sys_rst) wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle"); // see [RQ12]

    // Level register write, mirrors the control write sequence
    sequence s_level_write;
        write_strobe && word_addr == level_offset;
    endsequence

    // Every taken request is answered on the very next edge
    property p_ack_follows_take;
        @(posedge clk) disable iff (sys_rst) access |=> wb_ack_o;
    endproperty
    a_ack_follows_take: assert property (p_ack_follows_take) else $error("request not acked"); // see [RQ12]

    // No stray ack without a fresh request
    property p_no_stray_ack;
        @(posedge clk) disable iff (sys_rst) !access |=> !wb_ack_o;
    endproperty
    a_no_stray_ack: assert property (p_no_stray_ack) else $error("ack without request"); // see [RQ12]

    // Stored enable takes the written bit on the take edge
    property p_enable_store;
        @(posedge clk) disable iff (sys_rst) s_ctrl_write |=> converter_enable == $past(wdata[enable_bit]);
    endproperty
    a_enable_store: assert property (p_enable_store) else $error("enable not stored"); // see [RQ12]

    // Level code keeps only the five implemented bits
    property p_level_store;
        @(posedge clk) disable iff (sys_rst) s_level_write |=> level_code == $past(wdata[4:0]);
    endproperty
    a_level_store: assert property (p_level_store) else $error("level code not stored"); // see [RQ2]

    // Tap follows the stored code one edge later
    property p_tap_tracks;
        @(posedge clk) disable iff (sys_rst) ladder_tap == $past(level_code);
    endproperty
    a_tap_tracks: assert property (p_tap_tracks) else $error("tap lags wrongly"); // see [RQ3]

    // Second pad route follows its bit two edges after the write
    property p_pin2_route;
        @(posedge clk) disable iff (sys_rst) s_ctrl_write |=> ##1 reference_out_pin2 == $past(wdata[pin2_oe_bit], 2);
    endproperty
    a_pin2_route: assert property (p_pin2_route) else $error("pin2 route mismatch"); // see [RQ4]

    // Reserved code must never close a source switch
    property p_reserved_open;
        @(posedge clk) disable iff (sys_rst) positive_source_select == src_reserved
            |=> !source_supply_sw && !source_ext_pin_sw && !source_fixed_sw;
    endproperty
    a_reserved_open: assert property (p_reserved_open) else $error("reserved code closed a switch"); // see [RQ5]

    // A disabled converter leaves every source open
    property p_disabled_open;
        @(posedge clk) disable iff (sys_rst) !converter_enable
            |=> !source_supply_sw && !source_ext_pin_sw && !source_fixed_sw;
    endproperty
    a_disabled_open: assert property (p_disabled_open) else $error("source closed while off"); // see [RQ1]

    // Negative end is ground whenever the converter runs
    property p_ground_tracks;
        @(posedge clk) disable iff (sys_rst) negative_ground_sw == $past(converter_enable);
    endproperty
    a_ground_tracks: assert property (p_ground_tracks) else $error("ground switch wrong"); // see [RQ10]

    // Routed first pad reads zero at the top port
    property p_pin1_reads_zero;
        @(posedge clk) disable iff (sys_rst) pin1_output_enable |=> !pin1_read_value;
    endproperty
    a_pin1_reads_zero: assert property (p_pin1_reads_zero) else $error("pin1 read not zero"); // see [RQ7]

    // Routed second pad loses its digital driver and detector
    property p_pin2_override;
        @(posedge clk) disable iff (sys_rst) pin2_output_enable |=> pin2_drv_override && pin2_thr_override;
    endproperty
    a_pin2_override: assert property (p_pin2_override) else $error("pin2 override missing"); // see [RQ6]

    // Reset clears power, ladder tap and both pin routes
    property p_reset_outputs;
        @(posedge clk) sys_rst |=> !converter_power && ladder_tap == 5'h00 && !reference_out_pin1 && !reference_out_pin2;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not cleared"); // see [RQ8]

    // Sleep alone never disturbs the level code either
    property p_sleep_level_hold;
        @(posedge clk) disable iff (sys_rst) (sleep_i && !write_strobe) |=> $stable(level_code);
    endproperty
    a_sleep_level_hold: assert property (p_sleep_level_hold) else $error("level changed in sleep"); // see [RQ9]
endmodule // ladder_dac_control_regs

/* File: tb/ladder_dac_control_regs_tb_top.sv */
module ladder_dac_control_regs_tb_top
    import ladder_dac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, sleep_i, pin1_pad_in, pin2_pad_in;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rdat;
    logic [3:0] wb_sel_i, ov1, ov2; // Pad override groups per pin
    logic converter_power, source_supply_sw, source_ext_pin_sw, source_fixed_sw, negative_ground_sw;
    logic reference_out_pin1, reference_out_pin2, pin1_read_value, pin2_read_value;
    logic pin1_drv_override, pin1_thr_override, pin1_pullup_disable, pin1_ccd_disable;
    logic pin2_drv_override, pin2_thr_override, pin2_pullup_disable, pin2_ccd_disable;
    logic [4:0] ladder_tap;
    logic [7:0] lv [4] = '{8'h01, 8'h10, 8'h1f, 8'he0}; // Level codes incl. boundaries and masked bits
    int errors = 0;
    int samples_checked = 0;
    assign ov1 = {pin1_drv_override, pin1_thr_override, pin1_pullup_disable, pin1_ccd_disable};
    assign ov2 = {pin2_drv_override, pin2_thr_override, pin2_pullup_disable, pin2_ccd_disable};
    ladder_dac_control_regs i_dut (.clk(clk), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_ack_o(wb_ack_o), .sleep_i(sleep_i), .pin1_pad_in(pin1_pad_in), .pin2_pad_in(pin2_pad_in),
        .converter_power(converter_power), .ladder_tap(ladder_tap), .source_supply_sw(source_supply_sw),
        .source_ext_pin_sw(source_ext_pin_sw), .source_fixed_sw(source_fixed_sw),
        .negative_ground_sw(negative_ground_sw), .reference_out_pin1(reference_out_pin1),
        .reference_out_pin2(reference_out_pin2), .pin1_read_value(pin1_read_value),
        .pin2_read_value(pin2_read_value), .pin1_drv_override(pin1_drv_override),
        .pin1_thr_override(pin1_thr_override), .pin1_pullup_disable(pin1_pullup_disable),
        .pin1_ccd_disable(pin1_ccd_disable), .pin2_drv_override(pin2_drv_override),
        .pin2_thr_override(pin2_thr_override), .pin2_pullup_disable(pin2_pullup_disable),
        .pin2_ccd_disable(pin2_ccd_disable));
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Single comparison point, four-state exact
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Classic Wishbone cycle; waits for ack with a bound
    task automatic xfer(input logic we, input logic [3:0] adr, input logic [7:0] wd, input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {28'h0000000, adr};
        wb_dat_i <= {24'h000000, wd};
        wb_sel_i <= sel;
        @(posedge clk);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) begin
            errors++;
            $display("mismatch at %0t: no bus answer", $time);
        end
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] adr, input logic [7:0] wd);
        xfer(1'b1, adr, wd, 4'hf);
    endtask
    task automatic rd(input logic [3:0] adr, input logic [7:0] exp);
        xfer(1'b0, adr, 8'h00, 4'hf);
        check(rdat, {24'h000000, exp});
    endtask
    // Let derived outputs and pad overrides land
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    // Hang guard, well beyond the expected 150 or so cycles
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        final_report();
    end
    initial begin
        sys_rst = 1'b1;
        {wb_we_i, wb_cyc_i, wb_stb_i, sleep_i, pin1_pad_in, pin2_pad_in} = 6'h00;
        {wb_adr_i, wb_dat_i, wb_sel_i} = 68'h0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rd(control_offset, control_reset);
        rd(level_offset, level_reset);
        check({converter_power, reference_out_pin1, reference_out_pin2, ladder_tap}, 0);
        $display("test reset values done");
        wr(control_offset, 8'hff);
        rd(control_offset, 8'hbc);
        settle();
        check({converter_power, negative_ground_sw}, 2'b11);
        check({reference_out_pin1, reference_out_pin2}, 2'b11);
        $display("test control masking done");
        for (int s = 0; s < 4; s++) begin
            wr(control_offset, 8'h80 | 8'(s << 2));
            settle();
            check({source_supply_sw, source_ext_pin_sw, source_fixed_sw}, 3'b100 >> s);
        end
        $display("test source select done");
        foreach (lv[i]) begin
            wr(level_offset, lv[i]);
            rd(level_offset, lv[i] & level_write_mask);
            settle();
            check(ladder_tap, lv[i][4:0]);
        end
        xfer(1'b1, level_offset, 8'h15, 4'h0);
        rd(level_offset, 8'h00);
        wr(4'hc, 8'hff);
        rd(4'hc, 8'h00);
        $display("test level code done");
        pin1_pad_in <= 1'b1;
        pin2_pad_in <= 1'b1;
        wr(control_offset, 8'h20);
        settle();
        check({pin1_read_value, pin2_read_value}, 2'b01);
        check({ov1, ov2}, 8'hf0);
        rd(pin_status_offset, 8'h02);
        wr(control_offset, 8'h10);
        settle();
        check({pin1_read_value, pin2_read_value}, 2'b10);
        check({ov1, ov2}, 8'h0f);
        check(converter_power, 1'b0);
        $display("test pin override done");
        wr(control_offset, 8'ha4);
        sleep_i <= 1'b1;
        repeat (10) @(posedge clk);
        sleep_i <= 1'b0;
        rd(control_offset, 8'ha4);
        check({converter_power, source_ext_pin_sw}, 2'b11);
        $display("test sleep done");
        wr(level_offset, 8'h1f);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        check({converter_power, reference_out_pin1, reference_out_pin2, ladder_tap}, 0);
        rd(control_offset, 8'h00);
        rd(level_offset, 8'h00);
        $display("test second reset done");
        final_report();
    end
endmodule // ladder_dac_control_regs_tb_top
